// >>> dv/eeprom_host.sv
// Host controller model of the three-wire link
`timescale 1ns/1ps
module eeprom_host
(
	output logic shift_clock_pin,
	output logic chip_select_pin,
	output logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire logic serial_out_oe_n
);
initial
begin
	shift_clock_pin = 1'b0;
	chip_select_pin = 1'b0;
	serial_in_pin = 1'b0;
end
// Shift clock pulses only inside frames
task tick(input logic b);
	serial_in_pin = b;
	#7.5 shift_clock_pin = 1'b1;
	#7.5 shift_clock_pin = 1'b0;
endtask : tick
task open;
	#10 chip_select_pin = 1'b1;
	#10;
endtask : open
// Released input line flips so no stale value lingers
task close;
	#8 chip_select_pin = 1'b0;
	serial_in_pin = ~serial_in_pin;
	#40;
endtask : close
task send(input logic [31:0] v, input int n);
	for (int i = n - 1; i >= 0; i--)
		tick(v[i]);
endtask : send
task take(input logic clk, output logic b);
	if (clk)
		tick(~serial_in_pin);
	#60 b = serial_out_oe_n ? 1'bx : serial_out_pin;
endtask : take
endmodule : eeprom_host

// >>> dv/eeprom_port_properties.sv
// Checker of the serial memory port pins
`timescale 1ns/1ps
module eeprom_port_properties
#(
	parameter int unsigned PROG_CYCLES = 50
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic shift_clock_pin,
	input wire logic chip_select_pin,
	input wire logic serial_in_pin,
	input wire logic word_width_strap,
	input wire logic serial_out_pin,
	input wire logic serial_out_oe_n,
	input wire logic prog_busy
);
int busy_ff;
int idle_ff;
always_ff @(posedge core_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		busy_ff <= 0;
		idle_ff <= 0;
	end
	else
	begin
		busy_ff <= prog_busy ? busy_ff + 1 : 0;
		idle_ff <= chip_select_pin ? 0 : idle_ff + 1;
	end
end
default clocking @(posedge core_clk); endclocking
default disable iff (!rst_n);
AST_OE_OFF: assert property (!chip_select_pin && serial_out_oe_n |=> serial_out_oe_n)
	else $error("output driven while deselected");
AST_OE_ON: assert property (chip_select_pin [*5] |-> !serial_out_oe_n)
	else $error("output not driven while selected");
AST_OE_RELEASE: assert property ($fell(chip_select_pin) |-> ##[1:5] serial_out_oe_n)
	else $error("output not released");
AST_BUSY_MAX: assert property (busy_ff <= PROG_CYCLES)
	else $error("programming too long");
AST_BUSY_HOLDS: assert property ($rose(prog_busy) |=> prog_busy [*8])
	else $error("programming cut short");
AST_BUSY_ZERO: assert property ((chip_select_pin && prog_busy) [*5] |-> !serial_out_pin)
	else $error("status not low while busy");
AST_READY_ONE: assert property ($fell(prog_busy) && chip_select_pin |-> ##[1:4] serial_out_pin)
	else $error("status not high when ready");
AST_LAUNCH_NEAR: assert property ($rose(prog_busy) |-> idle_ff < 16)
	else $error("programming started late");
endmodule : eeprom_port_properties
bind eeprom_port eeprom_port_properties #(.PROG_CYCLES(PROG_CYCLES)) i_eeprom_port_properties
	(.core_clk, .rst_n, .shift_clock_pin, .chip_select_pin, .serial_in_pin, .word_width_strap,
	.serial_out_pin, .serial_out_oe_n, .prog_busy);

// >>> dv/eeprom_port_test.sv
// Self-checking bench of the serial memory port
`timescale 1ns/1ps
`include "eeprom_port_params.svh"
module eeprom_port_test;
logic core_clk;
logic rst_n;
logic word_width_strap;
logic shift_clock_pin;
logic chip_select_pin;
logic serial_in_pin;
logic serial_out_pin;
logic serial_out_oe_n;
logic prog_busy;
int bad_count;
int cmp_count;
logic [15:0] m16[256];
logic [15:0] m8[512];
bit en;
eeprom_port #(.PROG_CYCLES(50), .WORDS(512)) i_eeprom_port (.core_clk, .rst_n, .shift_clock_pin,
	.chip_select_pin, .serial_in_pin, .word_width_strap, .serial_out_pin, .serial_out_oe_n,
	.prog_busy);
eeprom_host i_eeprom_host (.shift_clock_pin, .chip_select_pin, .serial_in_pin, .serial_out_pin,
	.serial_out_oe_n);
initial
begin
	core_clk = 1'b0;
	forever #4 core_clk = ~core_clk;
end
task conclude;
	if (bad_count == 0 && cmp_count > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask : conclude
task chk(input logic [15:0] got, input logic [15:0] exp);
	cmp_count++;
	if (got !== exp)
	begin
		bad_count++;
		$display("mismatch at %0t got %h exp %h", $time, got, exp);
	end
endtask : chk
task wait_busy(input logic v);
	int i;
	for (i = 0; i < 400 && prog_busy !== v; i++)
		@(posedge core_clk);
	if (i == 400)
	begin
		bad_count++;
		conclude();
	end
endtask : wait_busy
function int abits();
	return word_width_strap ? 8 : 9;
endfunction : abits
function void put(int i, logic [15:0] v);
	if (abits() == 8 && i < 256)
		m16[i] = v;
	if (abits() == 9)
		m8[i] = v & 16'h00ff;
endfunction : put
task op(input logic [1:0] opc, input int a, input logic [15:0] d);
	int n;
	int s;
	bit pg;
	logic seen;
	n = abits();
	s = (a >> (n - 2)) & 3;
	pg = opc == `OP_WRITE || opc == `OP_ERASE
		|| opc == `OP_SPECIAL && s != `SUB_ENABLE && s != `SUB_DISABLE;
	i_eeprom_host.open();
	i_eeprom_host.send({1'b1, opc}, 3);
	i_eeprom_host.send(a, n);
	if (opc == `OP_WRITE || opc == `OP_SPECIAL && s == `SUB_FILL_ALL)
		i_eeprom_host.send(d, 80 - 8 * n);
	i_eeprom_host.close();
	if (opc == `OP_SPECIAL && s == `SUB_ENABLE)
		en = 1;
	if (opc == `OP_SPECIAL && s == `SUB_DISABLE)
		en = 0;
	seen = 1'b0;
	if (pg && !en)
	begin
		repeat (60) @(posedge core_clk) seen |= prog_busy;
		chk({15'h0, seen}, 16'h0);
	end
	else if (pg)
	begin
		wait_busy(1'b1);
		i_eeprom_host.open();
		repeat (6) @(posedge core_clk);
		chk({14'h0, serial_out_oe_n, serial_out_pin}, 16'h0);
		wait_busy(1'b0);
		repeat (6) @(posedge core_clk);
		chk({14'h0, serial_out_oe_n, serial_out_pin}, 16'h1);
		i_eeprom_host.close();
		for (int i = 0; i < 512; i++)
			if (opc == `OP_SPECIAL || i == a)
				put(i, opc == `OP_ERASE || s == `SUB_ERASE_ALL && opc == `OP_SPECIAL ? 16'hffff : d);
	end
endtask : op
task spc(input logic [1:0] s, input logic [15:0] d);
	op(`OP_SPECIAL, (s << (abits() - 2)) + $urandom % 64, d);
endtask : spc
task rd(input int a, input int cnt, input bit lead0);
	logic b;
	logic [15:0] w;
	int n;
	n = abits();
	i_eeprom_host.open();
	if (lead0)
		i_eeprom_host.send(2'b00, 2);
	i_eeprom_host.send({1'b1, `OP_READ}, 3);
	i_eeprom_host.send(a, n);
	i_eeprom_host.take(1'b0, b);
	chk({15'h0, b}, 16'h0);
	for (int k = 0; k < cnt; k++)
	begin
		w = 16'h0;
		for (int j = 0; j < 80 - 8 * n; j++)
		begin
			i_eeprom_host.take(1'b1, b);
			w = {w[14:0], b};
		end
		chk(w, n == 8 ? m16[a + k] : m8[a + k]);
	end
	i_eeprom_host.close();
endtask : rd
initial
begin
	rst_n = 1'b0;
	word_width_strap = 1'b1;
	bad_count = 0;
	cmp_count = 0;
	en = 0;
	void'($urandom(5318));
	repeat (3) @(posedge core_clk);
	rst_n <= 1'b1;
	repeat (4) @(posedge core_clk);
	op(`OP_WRITE, 5, 16'h1234);
	spc(`SUB_ENABLE, 0);
	spc(`SUB_ERASE_ALL, 0);
	op(`OP_WRITE, 254, $urandom);
	op(`OP_WRITE, 255, $urandom);
	op(`OP_WRITE, 255, $urandom);
	rd(253, 3, 1'b1);
	op(`OP_ERASE, 254, 0);
	rd(254, 2, 1'b0);
	@(posedge core_clk) word_width_strap <= 1'b0;
	repeat (4) @(posedge core_clk);
	spc(`SUB_FILL_ALL, $urandom);
	op(`OP_WRITE, 511, $urandom);
	rd(509, 3, 1'b0);
	spc(`SUB_DISABLE, 0);
	op(`OP_WRITE, 510, 16'h005a);
	spc(`SUB_ERASE_ALL, 0);
	rd(509, 3, 1'b0);
	conclude();
end
endmodule : eeprom_port_test

// >>> rtl/eeprom_port.sv
// Three-wire serial memory port with self-timed programming
// Operation
// - Strap high gives 16-bit words, low gives 8-bit words.
// - Floating strap reads high through pull-up, so 16-bit words; code has no pull-up, only reset loads high.
// - Instruction starts at the first 1 after select rise: lead bit 1, two-bit opcode, address.
// - Seven instructions decoded from opcode and, for 00, two address bits.
// - Opcode 10 reads: address then serial data out.
// - 00 with 11 enables programming.
// - Opcode 11 erases one addressed word.
// - Opcode 01 writes the following data word to the address.
// - 00 with 10 erases every word.
// - 00 with 01 fills every word with data, if enabled.
// - 00 with 00 disables programming.
// - Writes are self-timed; no erase needed first.
// - Programming starts only while enabled.
// - Select rising after a launch shows ready/busy on the output.
// - Programming cycle lasts at most 10 ms.
// - Read sends a 0 dummy bit, then auto-incrementing words.
// - Reset enters disabled; enabled stays until disable.
// - Status drives 0 while busy, 1 when ready.
// - Write cycle begins right after the last data bit.
`timescale 1ns/1ps
`include "eeprom_port_params.svh"
module eeprom_port
#(
	parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
	parameter int unsigned WORDS = 512
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic shift_clock_pin,
	input wire logic chip_select_pin,
	input wire logic serial_in_pin,
	input wire logic word_width_strap,
	output logic serial_out_pin,
	output logic serial_out_oe_n,
	output logic prog_busy
);
	import eeprom_port_pkg::*;

	// ---------------------------------------------------------------
	// Link side state (shift clock domain)
	// ---------------------------------------------------------------
	typedef struct packed {
		link_state_e st;
		logic [1:0] op;
		logic [8:0] addr;
		logic [15:0] data;
		logic [4:0] cnt;
		logic [15:0] shreg;
	} link_s;

	typedef struct packed {
		logic enabled;
		logic busy;
		logic [31:0] timer;
		logic seen_tgl;
		logic launched;
		out_pin_s pin;
	} core_s;

	link_s lnk_ff;
	link_s nxt_lnk;
	core_s core_ff;
	core_s nxt_core;
	logic [15:0] mem_ff [WORDS];
	logic [1:0] wide_ff;
	logic req_tgl_ff;
	logic nxt_req_tgl;
	prog_req_s req_ff;
	prog_req_s nxt_req;
	logic cs_sync;
	logic tgl_sync;
	logic wide_lnk;
	logic [15:0] rd_word;

	function automatic logic [8:0] word_index(input logic [8:0] a, input logic wide);
		word_index = wide ? {1'b0, a[7:0]} : a;
	endfunction : word_index

	// Strap passes two flops; reset loads high, an unconnected pin is not pulled up
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			wide_ff <= 2'h3;
		else
			wide_ff <= {wide_ff[0], word_width_strap};
	end

	sync_bit u_sync_lnk_wide (.clk(shift_clock_pin), .rst_n(chip_select_pin),
		.d(wide_ff[1]), .q(wide_lnk));

	// Read data is taken straight from storage; the array is only
	// changed by the core domain on the edge that sets busy, when reads are not valid
	assign rd_word = mem_ff[word_index(lnk_ff.addr, wide_lnk)];

	// Link logic: select low resets it, so each frame starts clean
	always_comb
	begin
		logic [4:0] alen;
		logic [4:0] dlen;
		nxt_lnk = lnk_ff;
		nxt_req_tgl = req_tgl_ff;
		nxt_req = req_ff;
		alen = wide_lnk ? `ADDR_BITS_X16 : `ADDR_BITS_X8;
		dlen = wide_lnk ? `DATA_BITS_X16 : `DATA_BITS_X8;
		case (lnk_ff.st)
			LNK_IDLE:
			begin
				if (serial_in_pin == `LEAD_BIT_VAL)
				begin
					nxt_lnk.st = LNK_OP;
					nxt_lnk.cnt = 5'h0;
				end
			end
			LNK_OP:
			begin
				nxt_lnk.op = {lnk_ff.op[0], serial_in_pin};
				nxt_lnk.cnt = lnk_ff.cnt + 5'h1;
				if (lnk_ff.cnt == 5'h1)
				begin
					nxt_lnk.st = LNK_ADDR;
					nxt_lnk.cnt = 5'h0;
				end
			end
			LNK_ADDR:
			begin
				nxt_lnk.addr = {lnk_ff.addr[7:0], serial_in_pin};
				nxt_lnk.cnt = lnk_ff.cnt + 5'h1;
				if (lnk_ff.cnt == alen - 5'h1)
				begin
					nxt_lnk.cnt = 5'h0;
					nxt_lnk.st = LNK_DONE;
					if (wide_lnk)
						nxt_lnk.addr[8] = 1'b0;
					case (lnk_ff.op)
						`OP_READ:
						begin
							nxt_lnk.st = LNK_READ;
							nxt_lnk.shreg = 16'h0;
						end
						`OP_WRITE: nxt_lnk.st = LNK_DATA;
						`OP_ERASE:
						begin
							nxt_req.cmd = CMD_ERASE;
							nxt_req.addr = nxt_lnk.addr;
							nxt_req_tgl = ~req_tgl_ff;
						end
						default:
						begin
							if (alen == `ADDR_BITS_X16
								? lnk_ff.addr[6:5] == `SUB_FILL_ALL
								: lnk_ff.addr[7:6] == `SUB_FILL_ALL)
								nxt_lnk.st = LNK_DATA;
							else
							begin
								nxt_req.addr = wide_lnk ? {2'h0, lnk_ff.addr[6:0]}
									: lnk_ff.addr[8:0];
								nxt_req.cmd = CMD_ERASE_ALL;
								nxt_req_tgl = ~req_tgl_ff;
								nxt_req.addr[8] = (wide_lnk ? lnk_ff.addr[6:5]
									: lnk_ff.addr[7:6]) == `SUB_ERASE_ALL;
							end
						end
					endcase
				end
			end
			LNK_DATA:
			begin
				nxt_lnk.data = {lnk_ff.data[14:0], serial_in_pin};
				nxt_lnk.cnt = lnk_ff.cnt + 5'h1;
				if (lnk_ff.cnt == dlen - 5'h1)
				begin
					nxt_lnk.st = LNK_DONE;
					nxt_req.cmd = (lnk_ff.op == `OP_WRITE) ? CMD_WRITE : CMD_FILL_ALL;
					nxt_req.addr = lnk_ff.addr;
					nxt_req.data = nxt_lnk.data;
					nxt_req_tgl = ~req_tgl_ff;
				end
			end
			LNK_READ:
			begin
				// Shift register is loaded after the dummy bit and each word
				nxt_lnk.cnt = lnk_ff.cnt + 5'h1;
				nxt_lnk.shreg = {lnk_ff.shreg[14:0], 1'b0};
				if (lnk_ff.cnt == 5'h0 || lnk_ff.cnt == dlen)
				begin
					nxt_lnk.shreg = wide_lnk ? rd_word : {rd_word[7:0], 8'h0};
					nxt_lnk.cnt = 5'h1;
					nxt_lnk.addr = wide_lnk ? {1'b0, lnk_ff.addr[7:0] + 8'h1}
						: lnk_ff.addr + 9'h1;
				end
			end
			LNK_DONE: nxt_lnk.st = LNK_DONE;
			default: nxt_lnk.st = LNK_IDLE;
		endcase
	end

	// Frame state clears while select is low; the request toggle and
	// payload below outlive the frame and clear only on reset
	always_ff @(posedge shift_clock_pin or negedge chip_select_pin or negedge rst_n)
	begin
		if (!chip_select_pin || !rst_n)
		begin
			lnk_ff.st <= LNK_IDLE;
			lnk_ff.op <= 2'h0;
			lnk_ff.addr <= 9'h0;
			lnk_ff.data <= 16'h0;
			lnk_ff.cnt <= 5'h0;
			lnk_ff.shreg <= 16'h0;
		end
		else
		begin
			lnk_ff.st <= nxt_lnk.st;
			lnk_ff.op <= nxt_lnk.op;
			lnk_ff.addr <= nxt_lnk.addr;
			lnk_ff.data <= nxt_lnk.data;
			lnk_ff.cnt <= nxt_lnk.cnt;
			lnk_ff.shreg <= nxt_lnk.shreg;
		end
	end

	always_ff @(posedge shift_clock_pin or negedge rst_n)
	begin
		if (!rst_n)
		begin
			req_tgl_ff <= 1'b0;
			req_ff <= '0;
		end
		else if (chip_select_pin)
		begin
			req_tgl_ff <= nxt_req_tgl;
			req_ff <= nxt_req;
		end
	end

	// ---------------------------------------------------------------
	// Core side: programming engine and output pin
	// ---------------------------------------------------------------
	sync_bit u_sync_cs (.clk(core_clk), .rst_n(rst_n), .d(chip_select_pin), .q(cs_sync));
	sync_bit u_sync_tgl (.clk(core_clk), .rst_n(rst_n), .d(req_tgl_ff), .q(tgl_sync));

	logic cs_prev_ff;
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			cs_prev_ff <= 1'b0;
		else
			cs_prev_ff <= cs_sync;
	end

	logic start_prog;
	logic sub_enable;
	logic sub_disable;
	always_comb
	begin
		sub_enable = 1'b0;
		sub_disable = 1'b0;
		start_prog = 1'b0;
		if (tgl_sync != core_ff.seen_tgl && req_ff.cmd == CMD_ERASE_ALL)
		begin
			// Special group except fill-all (CMD_FILL_ALL) rides on CMD_ERASE_ALL; addr[8] marks erase-all
			sub_enable = !req_ff.addr[8] && req_ff.addr[7:6] == `SUB_ENABLE
				|| !req_ff.addr[8] && req_ff.addr[6:5] == `SUB_ENABLE;
			sub_disable = !req_ff.addr[8] && !sub_enable;
		end
		if (tgl_sync != core_ff.seen_tgl && core_ff.enabled && !core_ff.busy)
			start_prog = !(req_ff.cmd == CMD_ERASE_ALL && !req_ff.addr[8]);
	end

	always_comb
	begin
		nxt_core = core_ff;
		nxt_core.seen_tgl = tgl_sync;
		if (sub_enable)
			nxt_core.enabled = 1'b1;
		if (sub_disable)
			nxt_core.enabled = 1'b0;
		if (start_prog)
		begin
			nxt_core.busy = 1'b1;
			nxt_core.launched = 1'b1;
			nxt_core.timer = PROG_CYCLES - 1;
		end
		else if (core_ff.busy)
		begin
			nxt_core.timer = core_ff.timer - 32'h1;
			if (core_ff.timer == 32'h0)
				nxt_core.busy = 1'b0;
		end
		if (cs_prev_ff && !cs_sync && !core_ff.busy && !start_prog)
			nxt_core.launched = 1'b0;
		nxt_core.pin.serial_out_oe_n = !cs_sync;
		if (core_ff.launched)
			nxt_core.pin.serial_out_pin = !core_ff.busy;
		else
			nxt_core.pin.serial_out_pin = lnk_ff.st == LNK_READ ? lnk_ff.shreg[15] : 1'b1;
	end

	// Array update: erase sets all ones, write overwrites directly
	always_ff @(posedge core_clk)
	begin
		if (start_prog)
		begin
			for (int i = 0; i < WORDS; i++)
			begin
				if (req_ff.cmd == CMD_ERASE_ALL)
					mem_ff[i] <= `ERASED_WORD;
				else if (req_ff.cmd == CMD_FILL_ALL)
					mem_ff[i] <= req_ff.data;
				else if (i == int'(word_index(req_ff.addr, wide_ff[1])))
					mem_ff[i] <= req_ff.cmd == CMD_ERASE ? `ERASED_WORD
						: req_ff.data;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			core_ff <= '0;
			core_ff.pin.serial_out_oe_n <= 1'b1;
		end
		else
			core_ff <= nxt_core;
	end

	assign serial_out_pin = core_ff.pin.serial_out_pin;
	assign serial_out_oe_n = core_ff.pin.serial_out_oe_n;
	assign prog_busy = core_ff.busy;
endmodule : eeprom_port

// >>> rtl/eeprom_port_params.svh
// Constants of the three-wire serial memory port
`ifndef EEPROM_PORT_PARAMS_SVH
`define EEPROM_PORT_PARAMS_SVH
`define CORE_CLK_MHZ 125
`define PROG_TIME_MS 10
`define PROG_CYCLES (`PROG_TIME_MS * 1000 * `CORE_CLK_MHZ)
`define LEAD_BIT_VAL 1'b1
`define OP_READ 2'b10
`define OP_WRITE 2'b01
`define OP_ERASE 2'b11
`define OP_SPECIAL 2'b00
`define SUB_ENABLE 2'b11
`define SUB_ERASE_ALL 2'b10
`define SUB_FILL_ALL 2'b01
`define SUB_DISABLE 2'b00
`define ERASED_WORD 16'hffff
`define ADDR_BITS_X8 5'h09
`define ADDR_BITS_X16 5'h08
`define DATA_BITS_X8 5'h08
`define DATA_BITS_X16 5'h10
`define ADDR_W 9
`endif

// >>> rtl/eeprom_port_pkg.sv
// Types of the three-wire serial memory port
package eeprom_port_pkg;
typedef enum logic [5:0] {
	LNK_IDLE = 6'h01,
	LNK_OP = 6'h02,
	LNK_ADDR = 6'h04,
	LNK_DATA = 6'h08,
	LNK_READ = 6'h10,
	LNK_DONE = 6'h20
} link_state_e;
typedef enum logic [2:0] {
	CMD_WRITE = 3'h0,
	CMD_ERASE = 3'h1,
	CMD_ERASE_ALL = 3'h2,
	CMD_FILL_ALL = 3'h3
} prog_cmd_e;
typedef struct packed {
	prog_cmd_e cmd;
	logic [8:0] addr;
	logic [15:0] data;
} prog_req_s;
typedef struct packed {
	logic serial_out_pin;
	logic serial_out_oe_n;
} out_pin_s;
endpackage : eeprom_port_pkg

// >>> rtl/sync_bit.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
module sync_bit
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic [1:0] pipe_ff;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			pipe_ff <= 2'h0;
		else
			pipe_ff <= {pipe_ff[0], d};
	end
	assign q = pipe_ff[1];
endmodule : sync_bit
